// ===== dv/dcr_master_model.sv
`timescale 1ns/10ps

module dcr_master_model (
   // Clock
   input  wire logic        clock_i,
   // Request side
   output logic             req_o,
   output logic             wr_o,
   output logic [15:0]      addr_o,
   output logic [15:0]      wdata_o,
   output logic [7:0]       count_o,
   // Answer side
   input  wire logic        ack_i,
   input  wire logic        err_i,
   input  wire logic [15:0] rdata_i
);
   // Answers that never came; the bench counts them as mismatches
   int timeouts = 0;

   initial begin
      req_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 16'hffff;
      wdata_o = 16'hffff;
      count_o = 8'h01;
   end

   // One word per request; released address and data lines show the inverse, never the old value
   task automatic xfer(input logic w, input logic [15:0] a, d, input logic [7:0] c,
                       output logic e, output logic [15:0] r);
      int n;
      @(posedge clock_i);
      req_o <= 1'b1;
      wr_o <= w;
      addr_o <= a;
      wdata_o <= d;
      count_o <= c;
      @(posedge clock_i);
      req_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      #1;
      for (n = 0; n < 4 && ack_i !== 1'b1; n++) begin
         @(posedge clock_i);
         #1;
      end
      if (ack_i !== 1'b1) begin
         timeouts++;
      end
      e = (ack_i === 1'b1) ? err_i : 1'bx;
      r = (ack_i === 1'b1) ? rdata_i : 16'hxxxx;
   endtask

   // Two consecutive writes in adjacent cycles, as a multi-register write
   task automatic burst(input logic [15:0] a0, d0, a1, d1);
      @(posedge clock_i);
      req_o <= 1'b1;
      wr_o <= 1'b1;
      addr_o <= a0;
      wdata_o <= d0;
      @(posedge clock_i);
      addr_o <= a1;
      wdata_o <= d1;
      @(posedge clock_i);
      req_o <= 1'b0;
      addr_o <= ~a1;
      wdata_o <= ~d1;
      #1;
   endtask
endmodule

// ===== dv/dcr_register_map_asserts.sv
`timescale 1ns/10ps
`include "dcr_defines.svh"

module dcr_register_map_asserts
   import dcr_pkg::*;
#(
   parameter int GROUPS = 12,
   parameter int NUMS   = 32
)(
   // Clock, reset and requests
   input wire logic           clock_i,
   input wire logic           rst_i,
   input wire logic           req_i,
   input wire logic           wr_i,
   input wire logic [15:0]    addr_i,
   input wire logic [15:0]    wdata_i,
   input wire logic [7:0]     count_i,
   input wire dcr_trip_t      trips_i,
   // Design outputs
   input wire logic           ack_o,
   input wire logic           err_o,
   input wire dcr_drive_cmd_t drive_cmd_o,
   input wire logic           fault_reset_o,
   input wire logic [7:0]     fault_code_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence cmd_wr_s;
      req_i && wr_i && addr_i == `DCR_ADDR_CMD;
   endsequence
   sequence ctl_wr_s;
      req_i && wr_i && addr_i == `DCR_ADDR_FAULT_CTL;
   endsequence
   // Trips win over a clear, so code checks need a quiet trip bus
   sequence quiet_s;
      trips_i == '0;
   endsequence

   ack_next_a: assert property (req_i |=> ack_o)
      else $error("no answer after request");
   run_go_a: assert property (cmd_wr_s ##0 wdata_i[1:0] == 2'b10 |=>
      drive_cmd_o.run_state == DCR_ST_RUN) else $error("run not taken");
   sel_apply_a: assert property (cmd_wr_s ##0 wdata_i[12] |=>
      drive_cmd_o.step_speed == $past(wdata_i[11:8]) &&
      drive_cmd_o.accel_set == $past(wdata_i[7:6])) else $error("selection lost");
   sel_hold_a: assert property (cmd_wr_s ##0 !wdata_i[12] |=>
      $stable(drive_cmd_o.step_speed) && $stable(drive_cmd_o.accel_set))
      else $error("selection changed");
   ext_code_a: assert property (ctl_wr_s ##0 wdata_i[1:0] == 2'b01
      ##0 fault_code_o == 8'h00 ##0 quiet_s ##1 quiet_s |=> fault_code_o == 8'h06)
      else $error("external code wrong");
   oc_code_a: assert property (trips_i.overcurrent_trip &&
      fault_code_o == 8'h00 |=> fault_code_o == 8'h01) else $error("oc code wrong");
   clr_pulse_a: assert property (ctl_wr_s ##0 wdata_i[1:0] == 2'b10
      ##1 !req_i |-> fault_reset_o ##1 !fault_reset_o) else $error("reset pulse wrong");
   // A write right behind the clear could set the external fault again
   clr_code_a: assert property (ctl_wr_s ##0 wdata_i[1:0] == 2'b10
      ##1 quiet_s ##0 !req_i ##1 quiet_s |=> fault_code_o == 8'h00)
      else $error("code not cleared");
   param_cnt_a: assert property (req_i && !wr_i && addr_i[15:8] < GROUPS &&
      addr_i[7:0] < NUMS && count_i != 8'h01 |=> ack_o && err_o)
      else $error("multi read accepted");
endmodule

bind dcr_register_map dcr_register_map_asserts #(.GROUPS(GROUPS), .NUMS(NUMS)) u_asserts (
   .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .wr_i(wr_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .count_i(count_i), .trips_i(trips_i), .ack_o(ack_o),
   .err_o(err_o), .drive_cmd_o(drive_cmd_o), .fault_reset_o(fault_reset_o),
   .fault_code_o(fault_code_o));

// ===== dv/testbench.sv
`timescale 1ns/10ps
`include "dcr_defines.svh"

module testbench
   import dcr_pkg::*;
;
   localparam int G = 12;
   localparam int N = 32;
   logic           clock_i    = 1'b0;
   logic           rst_i      = 1'b1;
   logic [15:0]    par_addr_i = 16'h0000;
   dcr_trip_t      trips_i    = '0;
   logic           req_i, wr_i, ack_o, err_o, external_trip_o, fault_reset_o, e;
   logic [15:0]    addr_i, wdata_i, rdata_o, par_data_o, freq_setpoint_o, w, v, a, r;
   logic [7:0]     count_i, fault_code_o;
   dcr_drive_cmd_t drive_cmd_o, cmd_exp;
   logic [7:0]     codes [8] = '{8'h01, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
   int             n_errors = 0;
   int             comparisons = 0;
   int             i;

   always #12.5 clock_i = ~clock_i;

   dcr_register_map #(.GROUPS(G), .NUMS(N)) u_dcr_register_map (
      .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .wr_i(wr_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .count_i(count_i), .ack_o(ack_o), .err_o(err_o),
      .rdata_o(rdata_o), .par_addr_i(par_addr_i), .par_data_o(par_data_o),
      .trips_i(trips_i), .drive_cmd_o(drive_cmd_o), .freq_setpoint_o(freq_setpoint_o),
      .external_trip_o(external_trip_o), .fault_reset_o(fault_reset_o),
      .fault_code_o(fault_code_o));

   dcr_master_model u_master (
      .clock_i(clock_i), .req_o(req_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i),
      .count_o(count_i), .ack_i(ack_o), .err_i(err_o), .rdata_i(rdata_o));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic dcr_drive_cmd_t exp_cmd(dcr_drive_cmd_t c, logic [15:0] d);
      dcr_drive_cmd_t n = c;
      if (d[1:0] != 2'b00) begin
         n.run_state = (d[1:0] == 2'b01) ? DCR_ST_STOP : (d[1]&d[0]) ? DCR_ST_JOG : DCR_ST_RUN;
      end
      if (d[5:4] != 2'b00) begin
         n.forward_rotation = (d[5:4] == 2'b11) ? ~c.forward_rotation : d[4];
      end
      if (d[12]) begin
         n.accel_set = d[7:6];
         n.step_speed = d[11:8];
      end
      n.comm_select = d[12];
      return n;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Reserved bits set on purpose: the clear must ignore them
   task automatic clear_fault;
      u_master.xfer(1'b1, `DCR_ADDR_FAULT_CTL, 16'hfffe, 8'h01, e, r);
      repeat (2) @(posedge clock_i);
      #1;
      check({8'h00, fault_code_o}, 16'h0000);
      check({15'h0, external_trip_o}, 16'h0000);
   endtask

   task automatic report_and_stop;
      n_errors = n_errors + u_master.timeouts;
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hd4f0));
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      cmd_exp = {DCR_ST_STOP, 1'b1, 7'h00};
      @(posedge clock_i);
      #1;
      check({6'h00, drive_cmd_o}, {6'h00, cmd_exp});
      check({8'h00, fault_code_o}, 16'h0000);
      for (i = 0; i < 24; i++) begin
         w = (i < 4) ? {3'b111, 1'b1, 4'(i * 5), i[1:0], i[1:0], 2'b11, i[1:0]} : 16'($urandom);
         u_master.xfer(1'b1, `DCR_ADDR_CMD, w, 8'h01, e, r);
         cmd_exp = exp_cmd(cmd_exp, w);
         check({6'h00, drive_cmd_o}, {6'h00, cmd_exp});
      end
      v = 16'($urandom);
      w = 16'($urandom) & 16'hefff;
      u_master.burst(`DCR_ADDR_FREQ, v, `DCR_ADDR_CMD, w);
      cmd_exp = exp_cmd(cmd_exp, w);
      check(freq_setpoint_o, v);
      check({6'h00, drive_cmd_o}, {6'h00, cmd_exp});
      for (i = 0; i < 4; i++) begin
         a = (i == 3) ? 16'h3fff : 16'(`DCR_ADDR_CMD + i);
         u_master.xfer(1'b0, a, 16'h0000, 8'h01, e, r);
         check({15'h0, e}, 16'h0001);
      end
      u_master.xfer(1'b1, 16'h3fff, 16'h0000, 8'h01, e, r);
      check({15'h0, e}, 16'h0001);
      check(freq_setpoint_o, v);
      for (i = 0; i < 8; i++) begin
         a = (i == 0) ? 16'h0401 : (i == 1) ? {8'(G - 1), 8'(N - 1)} :
             {8'($urandom_range(G - 1)), 8'($urandom_range(N - 1))};
         v = 16'($urandom);
         u_master.xfer(1'b1, a, v, 8'h01, e, r);
         u_master.xfer(1'b0, a, 16'h0000, 8'h01, e, r);
         check(r, v);
         u_master.xfer(1'b0, a, 16'h0000, 8'h02, e, r);
         check({15'h0, e}, 16'h0001);
         @(posedge clock_i);
         par_addr_i <= a;
         @(posedge clock_i);
         #1;
         check(par_data_o, v);
      end
      for (i = 0; i < 8; i++) begin
         @(posedge clock_i);
         trips_i <= dcr_trip_t'(8'h80 >> i);
         @(posedge clock_i);
         trips_i <= '0;
         repeat (2) @(posedge clock_i);
         #1;
         check({8'h00, fault_code_o}, {8'h00, codes[i]});
         clear_fault();
      end
      u_master.xfer(1'b1, `DCR_ADDR_FAULT_CTL, 16'h0001, 8'h01, e, r);
      check({15'h0, external_trip_o}, 16'h0001);
      u_master.xfer(1'b0, `DCR_ADDR_FAULT_CODE, 16'h0000, 8'h01, e, r);
      check(r, 16'h0006);
      clear_fault();
      report_and_stop();
   end
endmodule

// ===== src/dcr_defines.svh
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register addresses
`define DCR_ADDR_CMD        16'h2000
`define DCR_ADDR_FREQ       16'h2001
`define DCR_ADDR_FAULT_CTL  16'h2002
`define DCR_ADDR_FAULT_CODE 16'h2100

////////////////////////////////////////////////////////////////////////////////
// Command word fields
`define DCR_CMD_RUN_LSB     0
`define DCR_CMD_DIR_LSB     4
`define DCR_CMD_ACC_LSB     6
`define DCR_CMD_STEP_LSB    8
`define DCR_CMD_APPLY_BIT   12

// Fault control word fields
`define DCR_FCTL_EXT_BIT    0
`define DCR_FCTL_RST_BIT    1

////////////////////////////////////////////////////////////////////////////////
// Fault codes
`define DCR_CODE_NONE       8'h00
`define DCR_CODE_OC         8'h01
`define DCR_CODE_EXT        8'h06
`define DCR_CODE_SHORT      8'h07
`define DCR_CODE_CPU        8'h08
`define DCR_CODE_HWP        8'h09
`define DCR_CODE_OC_ACC     8'h0a
`define DCR_CODE_OC_DEC     8'h0b
`define DCR_CODE_OC_RUN     8'h0c
`define DCR_CODE_GROUND     8'h0d

////////////////////////////////////////////////////////////////////////////////
// Reset values and sizes
`define DCR_FREQ_RESET      16'h0000
`define DCR_PARAM_RESET     16'h0000
`define DCR_PARAM_GROUPS    12
`define DCR_PARAM_NUMS      32
`define DCR_READ_COUNT_ONE  8'h01

`endif

// ===== src/dcr_fault_latch.sv
`timescale 1ns/10ps
`include "dcr_defines.svh"

module dcr_fault_latch
   import dcr_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   // Events
   input  wire dcr_trip_t  trips_i,
   input  wire logic       external_trip_i,
   input  wire logic       clear_i,
   // Status
   output logic [7:0]      code_o
);

   logic [7:0] code;
   logic [7:0] next_code;
   logic [7:0] new_code;

   // Lowest code wins when several trips land together
   always_comb begin
      new_code = `DCR_CODE_NONE;
      if (trips_i.overcurrent_trip) begin
         new_code = `DCR_CODE_OC;
      end else if (external_trip_i) begin
         new_code = `DCR_CODE_EXT;
      end else if (trips_i.short_circuit_trip) begin
         new_code = `DCR_CODE_SHORT;
      end else if (trips_i.processor_fail_trip) begin
         new_code = `DCR_CODE_CPU;
      end else if (trips_i.hw_protection_trip) begin
         new_code = `DCR_CODE_HWP;
      end else if (trips_i.accel_overcurrent_trip) begin
         new_code = `DCR_CODE_OC_ACC;
      end else if (trips_i.decel_overcurrent_trip) begin
         new_code = `DCR_CODE_OC_DEC;
      end else if (trips_i.steady_overcurrent_trip) begin
         new_code = `DCR_CODE_OC_RUN;
      end else if (trips_i.ground_trip) begin
         new_code = `DCR_CODE_GROUND;
      end
   end

   // A trip in the clearing cycle still lands
   always_comb begin
      next_code = code;
      if (new_code != `DCR_CODE_NONE) begin
         next_code = new_code;
      end else if (clear_i) begin
         next_code = `DCR_CODE_NONE;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         code <= `DCR_CODE_NONE;
      end else begin
         code <= next_code;
      end
   end

   assign code_o = code;

endmodule

// ===== src/dcr_pkg.sv
package dcr_pkg;

   typedef enum logic [1:0] {
      DCR_RUN_NONE = 2'b00,
      DCR_RUN_STOP = 2'b01,
      DCR_RUN_GO   = 2'b10,
      DCR_RUN_JOG  = 2'b11
   } dcr_run_req_t;

   typedef enum logic [1:0] {
      DCR_DIR_NONE   = 2'b00,
      DCR_DIR_FWD    = 2'b01,
      DCR_DIR_REV    = 2'b10,
      DCR_DIR_TOGGLE = 2'b11
   } dcr_dir_req_t;

   typedef enum logic [1:0] {
      DCR_ST_STOP = 2'b00,
      DCR_ST_RUN  = 2'b01,
      DCR_ST_JOG  = 2'b10
   } dcr_run_state_t;

   typedef struct packed {
      dcr_run_state_t run_state;
      logic           forward_rotation;
      logic [1:0]     accel_set;
      logic [3:0]     step_speed;
      logic           comm_select;
   } dcr_drive_cmd_t;

   typedef struct packed {
      logic overcurrent_trip;
      logic short_circuit_trip;
      logic processor_fail_trip;
      logic hw_protection_trip;
      logic accel_overcurrent_trip;
      logic decel_overcurrent_trip;
      logic steady_overcurrent_trip;
      logic ground_trip;
   } dcr_trip_t;

endpackage

// ===== src/dcr_register_map.sv
`timescale 1ns/10ps
`include "dcr_defines.svh"

// Behaviour
// - Parameter address is group high, number low
// - Command bits 1:0 choose none/stop/run/jog
// - Command bits 5:4 choose none/forward/reverse/toggle
// - Command bits 7:6 choose accel set one-four
// - Command bits 11:8 choose one of sixteen speeds
// - Bit 12 enables speed and accel selections
// - Fault word: bit0 external fault, bit1 reset
// - Code 06 external, 07 short circuit
// - Codes 01 overcurrent, 08 processor, 09 hardware
// - Codes 10-12 double current accel/decel/steady
// - Code 13 ground fault
// - Consecutive register writes accepted back to back
module dcr_register_map
   import dcr_pkg::*;
#(
   parameter int GROUPS = `DCR_PARAM_GROUPS,
   parameter int NUMS   = `DCR_PARAM_NUMS
)(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // Register access from the link framer
   input  wire logic        req_i,
   input  wire logic        wr_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic [7:0]  count_i,
   output logic             ack_o,
   output logic             err_o,
   output logic [15:0]      rdata_o,
   // Drive core parameter lookup
   input  wire logic [15:0] par_addr_i,
   output logic [15:0]      par_data_o,
   // Trip sources
   input  wire dcr_trip_t   trips_i,
   // Drive control
   output dcr_drive_cmd_t   drive_cmd_o,
   output logic [15:0]      freq_setpoint_o,
   output logic             external_trip_o,
   output logic             fault_reset_o,
   output logic [7:0]       fault_code_o
);

   localparam int DEPTH = GROUPS * NUMS;
   localparam int IDX_W = $clog2(DEPTH);

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter store

   logic [15:0]      param_mem [DEPTH];
   logic             host_par_hit;
   logic [IDX_W-1:0] host_idx;
   logic             core_par_hit;
   logic [IDX_W-1:0] core_idx;
   logic [15:0]      next_par_data;
   logic [15:0]      par_data;

   // Group in the high byte, number in the low byte
   always_comb begin
      host_par_hit = (int'(addr_i[15:8]) < GROUPS) && (int'(addr_i[7:0]) < NUMS);
      host_idx     = IDX_W'(int'(addr_i[15:8]) * NUMS + int'(addr_i[7:0]));
      core_par_hit = (int'(par_addr_i[15:8]) < GROUPS) && (int'(par_addr_i[7:0]) < NUMS);
      core_idx     = IDX_W'(int'(par_addr_i[15:8]) * NUMS + int'(par_addr_i[7:0]));
      next_par_data = core_par_hit ? param_mem[core_idx] : 16'h0000;
   end

   // Write taken every cycle, so a multi-word write may stream
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            param_mem[i] <= `DCR_PARAM_RESET;
         end
         par_data <= 16'h0000;
      end else begin
         if (req_i && wr_i && host_par_hit) begin
            param_mem[host_idx] <= wdata_i;
         end
         par_data <= next_par_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command, setpoint and fault control

   dcr_drive_cmd_t drive_cmd;
   dcr_drive_cmd_t next_drive_cmd;
   logic [15:0]    freq;
   logic [15:0]    next_freq;
   logic           ext_trip;
   logic           next_ext_trip;
   logic           fault_reset;
   logic           next_fault_reset;
   logic           wr_cmd;
   logic           wr_fctl;
   dcr_run_req_t   run_req;
   dcr_dir_req_t   dir_req;

   always_comb begin
      wr_cmd           = req_i && wr_i && (addr_i == `DCR_ADDR_CMD);
      wr_fctl          = req_i && wr_i && (addr_i == `DCR_ADDR_FAULT_CTL);
      run_req          = dcr_run_req_t'(wdata_i[`DCR_CMD_RUN_LSB +: 2]);
      dir_req          = dcr_dir_req_t'(wdata_i[`DCR_CMD_DIR_LSB +: 2]);
      next_drive_cmd   = drive_cmd;
      next_freq        = freq;
      next_ext_trip    = ext_trip;
      next_fault_reset = 1'b0;
      // Reserved bits 3:2 and 15:13 are never looked at
      if (wr_cmd) begin
         case (run_req)
            DCR_RUN_STOP: begin
               next_drive_cmd.run_state = DCR_ST_STOP;
            end
            DCR_RUN_GO: begin
               next_drive_cmd.run_state = DCR_ST_RUN;
            end
            DCR_RUN_JOG: begin
               next_drive_cmd.run_state = DCR_ST_JOG;
            end
            default: begin
               next_drive_cmd.run_state = drive_cmd.run_state;
            end
         endcase
         case (dir_req)
            DCR_DIR_FWD: begin
               next_drive_cmd.forward_rotation = 1'b1;
            end
            DCR_DIR_REV: begin
               next_drive_cmd.forward_rotation = 1'b0;
            end
            DCR_DIR_TOGGLE: begin
               next_drive_cmd.forward_rotation = !drive_cmd.forward_rotation;
            end
            default: begin
               next_drive_cmd.forward_rotation = drive_cmd.forward_rotation;
            end
         endcase
         next_drive_cmd.comm_select = wdata_i[`DCR_CMD_APPLY_BIT];
         // Selections left as they were when the apply bit is clear
         if (wdata_i[`DCR_CMD_APPLY_BIT]) begin
            next_drive_cmd.accel_set  = wdata_i[`DCR_CMD_ACC_LSB +: 2];
            next_drive_cmd.step_speed = wdata_i[`DCR_CMD_STEP_LSB +: 4];
         end
      end
      if (req_i && wr_i && (addr_i == `DCR_ADDR_FREQ)) begin
         next_freq = wdata_i;
      end
      // Setting the external fault wins over a reset in the same word
      if (wr_fctl && wdata_i[`DCR_FCTL_EXT_BIT]) begin
         next_ext_trip = 1'b1;
      end else if (wr_fctl && wdata_i[`DCR_FCTL_RST_BIT]) begin
         next_ext_trip = 1'b0;
      end
      next_fault_reset = wr_fctl && wdata_i[`DCR_FCTL_RST_BIT];
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         drive_cmd   <= '{run_state: DCR_ST_STOP, forward_rotation: 1'b1,
                          accel_set: 2'h0, step_speed: 4'h0, comm_select: 1'b0};
         freq        <= `DCR_FREQ_RESET;
         ext_trip    <= 1'b0;
         fault_reset <= 1'b0;
      end else begin
         drive_cmd   <= next_drive_cmd;
         freq        <= next_freq;
         ext_trip    <= next_ext_trip;
         fault_reset <= next_fault_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fault code

   logic [7:0] fault_code;

   dcr_fault_latch u_fault_latch (
      .clock_i         (clock_i),
      .rst_i           (rst_i),
      .trips_i         (trips_i),
      .external_trip_i (ext_trip),
      .clear_i         (fault_reset),
      .code_o          (fault_code)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Answer path, one cycle after the request

   logic        ack;
   logic        next_ack;
   logic        err;
   logic        next_err;
   logic [15:0] rdata;
   logic [15:0] next_rdata;

   always_comb begin
      next_ack   = req_i;
      next_err   = 1'b0;
      next_rdata = 16'h0000;
      if (req_i && wr_i) begin
         if (host_par_hit) begin
            next_err = 1'b0;
         end else if (addr_i == `DCR_ADDR_CMD) begin
            next_err = 1'b0;
         end else if (addr_i == `DCR_ADDR_FREQ) begin
            next_err = 1'b0;
         end else if (addr_i == `DCR_ADDR_FAULT_CTL) begin
            next_err = 1'b0;
         end else begin
            next_err = 1'b1;
         end
      end else if (req_i) begin
         if (host_par_hit) begin
            // Multi-word parameter reads are refused
            next_err   = (count_i != `DCR_READ_COUNT_ONE);
            next_rdata = next_err ? 16'h0000 : param_mem[host_idx];
         end else if (addr_i == `DCR_ADDR_FAULT_CODE) begin
            next_rdata = {8'h00, fault_code};
         end else begin
            // Write-only words and unmapped addresses
            next_err = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ack   <= 1'b0;
         err   <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         ack   <= next_ack;
         err   <= next_err;
         rdata <= next_rdata;
      end
   end

   assign ack_o           = ack;
   assign err_o           = err;
   assign rdata_o         = rdata;
   assign par_data_o      = par_data;
   assign drive_cmd_o     = drive_cmd;
   assign freq_setpoint_o = freq;
   assign external_trip_o = ext_trip;
   assign fault_reset_o   = fault_reset;
   assign fault_code_o    = fault_code;

endmodule
